// File: rtl/cie_pkg.sv
/*
  package for the cpu interrupt entry sequencer: vector codes, stack layout,
  program counter widths and entry timing.
  assumes a 4-bit core with a 12-bit program counter and 4-bit data memory.
*/
package cie_pkg;

  localparam int          PC_STEP_W      = 8;
  localparam int          PC_PAGE_W      = 4;
  localparam int          DADDR_W        = 8;
  localparam logic [3:0]  RESET_PAGE     = 4'h1;
  localparam logic [7:0]  RESET_STEP     = 8'h00;
  localparam logic [3:0]  VECTOR_PAGE    = 4'h1;
  localparam logic [7:0]  VEC_CLOCK      = 8'h01;
  localparam logic [7:0]  VEC_STOPWATCH  = 8'h02;
  localparam logic [7:0]  VEC_INPUT      = 8'h04;
  localparam logic [7:0]  VEC_ALL        = 8'h07;
  localparam int          ENTRY_CYCLES   = 12;
  localparam logic [3:0]  ENTRY_LAST     = 4'(ENTRY_CYCLES - 1);
  localparam int          STACK_WORDS    = 3;
  localparam logic [3:0]  PUSH_AT0       = 4'h1;
  localparam logic [3:0]  PUSH_AT1       = 4'h2;
  localparam logic [3:0]  PUSH_AT2       = 4'h3;
  localparam logic [3:0]  LOAD_AT        = 4'ha;   // load shows in the last busy cycle
  localparam logic [7:0]  MREG_BASE      = 8'h00;
  localparam logic [7:0]  MREG_LAST      = 8'h0f;

  // program counter as page plus step
  typedef struct packed {
    logic [PC_PAGE_W-1:0] page;
    logic [PC_STEP_W-1:0] step;
  } cie_pc_s;

  // one data memory write
  typedef struct packed {
    logic               en;
    logic [DADDR_W-1:0] addr;
    logic [3:0]         data;
  } cie_wr_s;

  typedef enum logic [1:0] {CIE_RUN, CIE_WAIT, CIE_ENTRY} cie_state_e;

endpackage

// File: rtl/cie_entry.sv
/*
  cpu interrupt entry sequencer: waits for the running instruction to end,
  pushes the program counter as three words onto the data memory stack,
  then loads the page 1 vector formed from the pending sources.
  assumes the core pulses instr_done at the end of each instruction and
  honours pc_load / mem_wr during entry_busy; sources are synchronous.
*/
//
// Contract
// RULE1 - accepted request waits until the current instruction finishes
// RULE2 - first step pushes the next instruction address onto the ram stack
// RULE3 - second step loads the program counter with the selected vector
// RULE4 - push plus vector load take exactly twelve system clock cycles
// RULE5 - vector step is the or of clock 01, stopwatch 02, input 04
// RULE6 - all three sources pending together vector to page 1 step 07
// RULE7 - vector location holds a software branch to the handler
// RULE8 - interrupt entry uses three 4-bit stack words
// RULE9 - data addresses 000 to 00f reachable as pointer-selected registers
// RULE10 - initial reset sets page 1 and step 00
// RULE11 - factor flags clear to zero when read by the cpu
// RULE12 - accept only with interrupt enable set, clear it on entry
`timescale 1ns/1ps
`default_nettype none
module cie_entry
  import cie_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 irq_clock,
  input  wire logic                 irq_stopwatch,
  input  wire logic                 irq_input,
  input  wire logic                 factor_read,
  input  wire logic [2:0]           factor_read_sel,
  input  wire logic                 instr_done,
  input  wire cie_pc_s              pc_next,
  input  wire logic                 ie_set,
  input  wire logic                 ie_clr,
  input  wire logic [7:0]           sp_in,
  input  wire logic [3:0]           register_pointer,
  output logic [2:0]                factor_flags,
  output logic                      ie,
  output logic                      entry_busy,
  output cie_pc_s                   pc_load_val,
  output logic                      pc_load,
  output cie_wr_s                   mem_wr,
  output logic [7:0]                sp_out,
  output logic [DADDR_W-1:0]        mreg_addr
);

  cie_state_e          state;
  logic [3:0]          cyc;
  logic [2:0]          latched;
  cie_pc_s             saved_pc;
  logic                pending;
  logic                accept;

  assign pending = |factor_flags;
  assign accept  = (state == CIE_RUN) && pending && ie;           // RULE12

  // factor flags: set by source events, cleared when read; set wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      factor_flags <= 3'h0;
    end else begin
      factor_flags <= (factor_flags & ~({3{factor_read}} & factor_read_sel)) // RULE11
                      | {irq_input, irq_stopwatch, irq_clock};
    end
  end

  // interrupt enable flag, cleared by entry
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ie <= 1'b0;
    end else if (accept) begin
      ie <= 1'b0;                                                    // RULE12
    end else if (ie_set) begin
      ie <= 1'b1;
    end else if (ie_clr) begin
      ie <= 1'b0;
    end
  end

  // sequencer: wait for instruction end, then a twelve cycle entry
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state    <= CIE_RUN;
      cyc      <= 4'h0;
      latched  <= 3'h0;
      saved_pc <= '0;
    end else begin
      unique case (state)
        CIE_RUN: begin
          if (accept) begin
            state <= CIE_WAIT;
          end
        end
        CIE_WAIT: begin
          if (instr_done) begin                                      // RULE1
            state    <= CIE_ENTRY;
            cyc      <= 4'h0;
            saved_pc <= pc_next;                                     // RULE2
            latched  <= factor_flags;
          end
        end
        CIE_ENTRY: begin
          if (cyc == ENTRY_LAST) begin                               // RULE4
            state <= CIE_RUN;
          end
          cyc <= cyc + 4'h1;
        end
      endcase
    end
  end

  assign entry_busy = (state == CIE_ENTRY);

  // stack pushes: three words, stack pointer decremented before each
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_wr <= '0;
      sp_out <= 8'h00;
    end else begin
      mem_wr.en <= 1'b0;
      if (state == CIE_WAIT && instr_done) begin
        sp_out <= sp_in;
      end else if (entry_busy && (cyc == PUSH_AT0 || cyc == PUSH_AT1
                                  || cyc == PUSH_AT2)) begin          // RULE8
        mem_wr.en   <= 1'b1;
        mem_wr.addr <= sp_out - 8'h01;
        sp_out      <= sp_out - 8'h01;
        unique case (cyc)
          PUSH_AT0: mem_wr.data <= saved_pc.page;                    // RULE2
          PUSH_AT1: mem_wr.data <= saved_pc.step[7:4];
          default:  mem_wr.data <= saved_pc.step[3:0];
        endcase
      end
    end
  end

  // program counter load: reset vector, then interrupt vector
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc_load          <= 1'b1;                                      // RULE10
      pc_load_val.page <= RESET_PAGE;
      pc_load_val.step <= RESET_STEP;
    end else if (entry_busy && cyc == LOAD_AT) begin
      pc_load          <= 1'b1;                                      // RULE3
      pc_load_val.page <= VECTOR_PAGE;
      pc_load_val.step <= (latched[0] ? VEC_CLOCK : 8'h00)           // RULE5 RULE6
                        | (latched[1] ? VEC_STOPWATCH : 8'h00)
                        | (latched[2] ? VEC_INPUT : 8'h00);
    end else begin
      pc_load <= 1'b0;   // core then fetches the branch at the vector RULE7
    end
  end

  // memory register address from the register pointer
  assign mreg_addr = MREG_BASE | {4'h0, register_pointer};          // RULE9

  property p_entry_len;
    @(posedge clk) disable iff (!rst_b)
      $rose(entry_busy) |-> entry_busy [*8] ##1 entry_busy [*4] ##1 !entry_busy;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry not 12 cycles"); // RULE4

  property p_vec_all;
    @(posedge clk) disable iff (!rst_b)
      (entry_busy && cyc == LOAD_AT && latched == 3'h7) |=> pc_load_val.step == VEC_ALL;
  endproperty
  a_vec_all: assert property (p_vec_all) else $error("all sources not step 07"); // RULE6

  property p_vec_mask;
    @(posedge clk) disable iff (!rst_b)
      pc_load && entry_busy |-> pc_load_val.step == {5'h0, latched}
                                && pc_load_val.page == VECTOR_PAGE;
  endproperty
  a_vec_mask: assert property (p_vec_mask) else $error("vector not source mask"); // RULE5

  property p_three_push;
    @(posedge clk) disable iff (!rst_b)
      $rose(entry_busy) |=> !mem_wr.en ##1 mem_wr.en [*3] ##1 !mem_wr.en;
  endproperty
  a_three_push: assert property (p_three_push) else $error("not three pushes"); // RULE8

  property p_wait_done;
    @(posedge clk) disable iff (!rst_b)
      $rose(entry_busy) |-> $past(instr_done);
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("entry before instr end"); // RULE1

  property p_ie_clear;
    @(posedge clk) disable iff (!rst_b)
      accept |=> !ie;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable not cleared"); // RULE12

  property p_push_pc;
    @(posedge clk) disable iff (!rst_b)
      $rose(mem_wr.en) && entry_busy |-> mem_wr.data == saved_pc.page;
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("first push not pc page"); // RULE2

  property p_load_end;
    @(posedge clk) disable iff (!rst_b)
      $fell(entry_busy) |-> $past(pc_load);
  endproperty
  a_load_end: assert property (p_load_end) else $error("vector not loaded"); // RULE3

  property p_read_clr;
    @(posedge clk) disable iff (!rst_b)
      factor_read && factor_read_sel[0] && !irq_clock |=> !factor_flags[0];
  endproperty
  a_read_clr: assert property (p_read_clr) else $error("flag not cleared"); // RULE11

endmodule
`default_nettype wire

// File: verification/cie_src.sv
/*
  model of the three interrupt sources: clock timer, stopwatch, input port.
  assumes the bench requests events on fire, changed at the falling edge;
  events are launched by non-blocking assignment on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cie_src (
  input  wire logic       clk,
  input  wire logic [2:0] fire,
  output logic            irq_clock = 1'b0,
  output logic            irq_stopwatch = 1'b0,
  output logic            irq_input = 1'b0
);
  // one-cycle event per requested source; taking fire on the rising edge
  // avoids a race with the bench, which changes it on the falling edge
  always @(posedge clk) begin
    {irq_input, irq_stopwatch, irq_clock} <= fire;
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
/*
  bench for the interrupt entry sequencer: every source mix, refusal, reset.
  assumes cie_src as the event sources and a core modelled by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import cie_pkg::*;
;
  logic       clk = 0, rst_b = 0, fr = 0, idn = 0, ies = 0, iec = 0;
  logic       irq_c, irq_s, irq_i, ie, busy, pcl;
  logic [2:0] fire = 0, sel = 0, flags;
  logic [7:0] sp_in = 0, sp_out, maddr;
  logic [3:0] rp = 0;
  cie_pc_s    pcn = '0, pcv;
  cie_wr_s    wr;
  int         n_fail = 0, n_tests = 0;

  cie_src i_cie_src (.clk, .fire, .irq_clock(irq_c), .irq_stopwatch(irq_s),
    .irq_input(irq_i));
  cie_entry i_cie_entry (.clk, .rst_b, .irq_clock(irq_c), .irq_stopwatch(irq_s),
    .irq_input(irq_i), .factor_read(fr), .factor_read_sel(sel), .instr_done(idn),
    .pc_next(pcn), .ie_set(ies), .ie_clr(iec), .sp_in, .register_pointer(rp),
    .factor_flags(flags), .ie, .entry_busy(busy), .pc_load_val(pcv),
    .pc_load(pcl), .mem_wr(wr), .sp_out, .mreg_addr(maddr));

  // clock
  always #5 clk = ~clk;

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task end_sim;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // expected vector step: VEC_ALL for all three sources, else one package code per pending source, or-ed together
  function automatic logic [7:0] exp_step(input logic [2:0] m);
    case (m)
      3'h7: exp_step = VEC_ALL;
      default: begin
        exp_step = 8'h00;
        if (m[0]) exp_step = exp_step | VEC_CLOCK;
        if (m[1]) exp_step = exp_step | VEC_STOPWATCH;
        if (m[2]) exp_step = exp_step | VEC_INPUT;
      end
    endcase
  endfunction

  // read the factor flags, which must then be clear
  task clr_flags;
    @(negedge clk) begin fr = 1; sel = 3'h7; end
    @(negedge clk) fr = 0;
    @(negedge clk) chk("flags_clr", 0, flags);
  endtask

  // one interrupt entry with a given source mix
  task entry(input logic [2:0] m);
    int nb, nw, np;
    logic [7:0] sp;
    logic [11:0] pc;
    nb = 0; nw = 0; np = 0;
    @(negedge clk) begin ies = 1; fire = m; sp_in = 8'($urandom); pcn = 12'($urandom); end
    sp = sp_in; pc = pcn; rp = 4'($urandom);
    #1 chk("mreg", {8'h0, 4'h0, rp}, maddr);
    @(negedge clk) begin ies = 0; fire = 0; end
    repeat (3 + $urandom % 3) @(negedge clk) chk("busy_wait", 0, busy);
    idn = 1;
    repeat (16) begin
      @(negedge clk) idn = 0;
      nb += busy;
      if (wr.en) begin
        chk("push_addr", 8'(sp - 1 - nw), wr.addr);
        chk("push_data", 4'(pc >> (8 - 4 * nw)), wr.data);
        nw++;
      end
      if (pcl) begin
        np++;
        chk("vector", {VECTOR_PAGE, exp_step(m)}, pcv);
      end
    end
    chk("busy_len", 12, nb);
    chk("pushes", 3, nw);
    chk("loads", 1, np);
    chk("sp_out", 8'(sp - 3), sp_out);
    chk("ie_off", 0, ie);
    chk("flags", m, flags);
    clr_flags();
  endtask

  initial begin
    void'($urandom(32'h0913));
    repeat (12) @(negedge clk);
    chk("rst_load", 1, pcl);
    chk("rst_pc", {RESET_PAGE, RESET_STEP}, pcv);
    rst_b = 1;
    @(negedge clk) chk("rst_drop", 0, pcl);
    for (int m = 1; m < 8; m++) entry(3'(m));
    entry(3'($urandom % 7 + 1));
    // refusal: enable set, then cleared by software in the same cycle as the source fires
    @(negedge clk) ies = 1;
    @(negedge clk) begin ies = 0; iec = 1; fire = 3'($urandom % 7 + 1); end
    @(negedge clk) begin iec = 0; fire = 0; end
    chk("ie_clr", 0, ie);
    repeat (8) begin
      @(negedge clk) idn = ~idn;
      chk("refused", 0, busy);
    end
    idn = 0;
    clr_flags();
    // reset in the middle of an entry, then a clean entry after it
    @(negedge clk) begin ies = 1; fire = 3'h1; end
    @(negedge clk) begin ies = 0; fire = 0; end
    repeat (3) @(negedge clk);
    idn = 1;
    @(negedge clk) idn = 0;
    repeat (3) @(negedge clk);
    chk("mid_busy", 1, busy);
    rst_b = 0;
    repeat (2) @(negedge clk);
    chk("mid_load", 1, pcl);
    chk("mid_pc", {RESET_PAGE, RESET_STEP}, pcv);
    chk("mid_idle", 0, busy);
    chk("mid_flags", 0, flags);
    chk("mid_ie", 0, ie);
    chk("mid_sp", 0, sp_out);
    rst_b = 1;
    @(negedge clk) chk("mid_drop", 0, pcl);
    entry(3'h5);
    end_sim();
  end

  // watchdog
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
